/* File: design/bus_bridge_unit.sv */
// Bridge between the system packet bus and the module's local bus.
// Assumes the local-bus glue lives on the same clock and keeps its side.
`timescale 1ns/1ns
module bus_bridge_unit
  import bridge_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  bridge_link_if.bridge_end lb,
  input wire logic proc_mode,
  input wire logic [1:0] own_type,
  input wire logic seq_en,
  input wire logic [31:0] seq_base,
  input wire logic [31:0] seq_mask,
  input wire logic in_valid,
  input wire logic in_msg,
  input wire logic in_cpu,
  input wire logic [1:0] in_src,
  input wire logic in_wr,
  input wire logic [31:0] in_addr,
  input wire logic [31:0] in_data,
  input wire logic [3:0] in_be,
  input wire logic [1:0] in_cnt,
  output logic in_ready,
  output logic rep_valid,
  output logic [1:0] rep_kind,
  output logic [31:0] rep_data,
  output logic rep_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_wr,
  output logic [31:0] out_addr,
  output logic [31:0] out_data,
  output logic [3:0] out_be,
  output logic out_seq,
  input wire logic orep_valid,
  input wire logic [1:0] orep_kind,
  input wire logic [31:0] orep_data,
  output logic [1:0] msg_int,
  input wire logic [1:0] msg_clr,
  output logic deadlock
);
  import bridge_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_ADDR = 2'b01, M_DATA = 2'b10} mstate_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_SEND = 3'b010, S_WAIT = 3'b011, S_DONE = 3'b100
  } sstate_t;

  typedef struct packed {
    mstate_t ms;
    sstate_t ss;
    logic [31:0] m_data;
    logic m_wr;
    logic [1:0] m_cnt;
    logic s_acked;
    logic [TMR_W-1:0] in_tmr;
    logic [TMR_W-1:0] out_tmr;
    logic [31:0] lad_o;
    logic lad_oe;
    logic ads;
    logic wr;
    logic [3:0] be;
    logic [1:0] cnt;
    logic rdy;
    logic hold;
    logic in_ready;
    logic rep_valid;
    logic [1:0] rep_kind;
    logic [31:0] rep_data;
    logic rep_last;
    logic out_valid;
    logic out_wr;
    logic [31:0] out_addr;
    logic [31:0] out_data;
    logic [3:0] out_be;
    logic out_seq;
    logic [1:0] msg_int;
    logic deadlock;
  } bstate_t;

  bstate_t r_reg;
  bstate_t r_next;

  logic out_busy;
  logic may_reissue;
  logic mem_allowed;
  logic [1:0] msg_set;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ads = 1'b0;
    r_next.rdy = 1'b0;
    r_next.in_ready = 1'b0;
    r_next.rep_valid = 1'b0;
    r_next.rep_last = 1'b0;
    r_next.deadlock = 1'b0;
    msg_set = 2'b00;

    // Our own outbound request still waiting on the packet bus
    out_busy = (r_reg.ss == S_SEND) || (r_reg.ss == S_WAIT);
    may_reissue = out_busy && (r_reg.out_tmr >= TMR_W'(REISSUE_CYCLES));
    // Active module never lets an inbound request onto its local bus
    mem_allowed = !proc_mode || ((own_type == MT_MIXED) && (in_src == MT_ACTIVE));

    // Deadlock watch: runs only while an inbound request waits
    if (in_valid) begin
      if (r_reg.in_tmr != {TMR_W{1'b1}}) begin
        r_next.in_tmr = r_reg.in_tmr + TMR_W'(1);
      end
      r_next.deadlock = (r_reg.in_tmr == TMR_W'(DEADLOCK_CYCLES - 1));
    end else begin
      r_next.in_tmr = '0;
    end

    // Outbound age, used to decide on reissue replies
    if (out_busy) begin
      if (r_reg.out_tmr != {TMR_W{1'b1}}) begin
        r_next.out_tmr = r_reg.out_tmr + TMR_W'(1);
      end
    end else begin
      r_next.out_tmr = '0;
    end

    // Inbound side: bridge as local-bus master
    unique case (r_reg.ms)
      M_IDLE: begin
        if (in_valid && !r_reg.in_ready) begin
          if (in_msg) begin
            r_next.in_ready = 1'b1;
            r_next.rep_valid = 1'b1;
            r_next.rep_last = 1'b1;
            // Passive and memory-mode ends have no processor to tell
            if (!proc_mode || (own_type == MT_PASSIVE) || r_reg.msg_int[in_cpu]) begin
              r_next.rep_kind = RK_NACK;
            end else begin
              r_next.rep_kind = RK_OK;
              msg_set[in_cpu] = 1'b1;
            end
          end else if (!mem_allowed) begin
            r_next.in_ready = 1'b1;
            r_next.rep_valid = 1'b1;
            r_next.rep_last = 1'b1;
            r_next.rep_kind = RK_NACK;
          end else if (may_reissue) begin
            r_next.in_ready = 1'b1;
            r_next.rep_valid = 1'b1;
            r_next.rep_last = 1'b1;
            r_next.rep_kind = RK_REISSUE;
            r_next.hold = 1'b0;
          end else if (proc_mode && !lb.gl_hlda) begin
            // Mixed module shares its bus with local masters
            r_next.hold = 1'b1;
          end else begin
            r_next.in_ready = 1'b1;
            r_next.ads = 1'b1;
            r_next.lad_o = in_addr;
            r_next.lad_oe = 1'b1;
            r_next.wr = in_wr;
            r_next.be = in_be;
            r_next.cnt = in_wr ? 2'h0 : in_cnt;
            r_next.m_cnt = in_wr ? 2'h0 : in_cnt;
            r_next.m_wr = in_wr;
            r_next.m_data = in_data;
            r_next.ms = M_ADDR;
          end
        end
      end
      M_ADDR: begin
        // Writes put data on the bus; reads release it to the glue
        r_next.lad_o = r_reg.m_data;
        r_next.lad_oe = r_reg.m_wr;
        r_next.ms = M_DATA;
      end
      M_DATA: begin
        if (lb.gl_rdy) begin
          r_next.rep_valid = 1'b1;
          r_next.rep_kind = RK_OK;
          r_next.rep_data = r_reg.m_wr ? 32'h0 : lb.local_addr_data;
          r_next.rep_last = (r_reg.m_cnt == 2'h0);
          if (r_reg.m_cnt == 2'h0) begin
            r_next.lad_oe = 1'b0;
            r_next.hold = 1'b0;
            r_next.ms = M_IDLE;
          end else begin
            r_next.m_cnt = r_reg.m_cnt - 2'h1;
          end
        end
      end
      default: r_next.ms = M_IDLE;
    endcase

    // Outbound side: bridge as slave, processor mode only
    unique case (r_reg.ss)
      S_IDLE: begin
        if (proc_mode && lb.gl_ads) begin
          r_next.out_addr = lb.local_addr_data;
          r_next.out_wr = lb.gl_wr;
          r_next.out_be = lb.gl_be;
          r_next.out_data = 32'h0;
          r_next.out_seq = seq_en && ((lb.local_addr_data & seq_mask) == (seq_base & seq_mask));
          r_next.s_acked = 1'b0;
          r_next.out_valid = !lb.gl_wr;
          r_next.ss = lb.gl_wr ? S_ADDR : S_SEND;
        end
      end
      S_ADDR: begin
        r_next.out_data = lb.local_addr_data;
        r_next.out_valid = 1'b1;
        r_next.ss = S_SEND;
      end
      S_SEND: begin
        if (out_ready) begin
          r_next.out_valid = 1'b0;
          r_next.ss = S_WAIT;
          // Plain writes post early; ordered ones hold wait states
          if (r_reg.out_wr && !r_reg.out_seq && !r_reg.s_acked) begin
            r_next.rdy = 1'b1;
            r_next.s_acked = 1'b1;
          end
        end
      end
      S_WAIT: begin
        if (orep_valid) begin
          if (orep_kind == RK_REISSUE) begin
            // Resend the same request so order is kept here
            r_next.out_valid = 1'b1;
            r_next.ss = S_SEND;
          end else if (r_reg.s_acked) begin
            r_next.ss = S_IDLE;
          end else begin
            r_next.rdy = 1'b1;
            r_next.lad_o = orep_data;
            r_next.lad_oe = !r_reg.out_wr;
            r_next.ss = S_DONE;
          end
        end
      end
      S_DONE: begin
        r_next.lad_oe = 1'b0;
        r_next.ss = S_IDLE;
      end
      default: r_next.ss = S_IDLE;
    endcase

    // New message wins over a clear in the same cycle
    r_next.msg_int = (r_reg.msg_int & ~msg_clr) | msg_set;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Every output is a field of the state register
  assign lb.br_lad_o = r_reg.lad_o;
  assign lb.br_lad_oe = r_reg.lad_oe;
  assign lb.br_ads = r_reg.ads;
  assign lb.br_wr = r_reg.wr;
  assign lb.br_be = r_reg.be;
  assign lb.br_cnt = r_reg.cnt;
  assign lb.br_rdy = r_reg.rdy;
  assign lb.br_hold = r_reg.hold;
  assign in_ready = r_reg.in_ready;
  assign rep_valid = r_reg.rep_valid;
  assign rep_kind = r_reg.rep_kind;
  assign rep_data = r_reg.rep_data;
  assign rep_last = r_reg.rep_last;
  assign out_valid = r_reg.out_valid;
  assign out_wr = r_reg.out_wr;
  assign out_addr = r_reg.out_addr;
  assign out_data = r_reg.out_data;
  assign out_be = r_reg.out_be;
  assign out_seq = r_reg.out_seq;
  assign msg_int = r_reg.msg_int;
  assign deadlock = r_reg.deadlock;

endmodule // bus_bridge_unit

/* File: design/bridge_pkg.sv */
// Shared constants for the local-bus bridge and its partner-side glue logic.
// Assumes both ends share one synchronous clock.
package bridge_pkg;

  // ----------------------------------------
  // Module types and reply kinds
  // ----------------------------------------
  localparam logic [1:0] MT_ACTIVE = 2'h0;
  localparam logic [1:0] MT_PASSIVE = 2'h1;
  localparam logic [1:0] MT_MIXED = 2'h2;

  localparam logic [1:0] RK_OK = 2'h0;
  localparam logic [1:0] RK_NACK = 2'h1;
  localparam logic [1:0] RK_REISSUE = 2'h2;
  localparam logic [1:0] RK_BAD = 2'h3;

  // ----------------------------------------
  // Address layout
  // ----------------------------------------
  localparam logic [7:0] MSG_SPACE_TAG = 8'hFF;
  localparam int MSG_TAG_LSB = 24;
  localparam int WORD_LSB = 2;
  localparam logic [3:0] BE_ALL = 4'hF;

  // ----------------------------------------
  // Timing counts, in clock cycles, and the timer width in bits
  // ----------------------------------------
  localparam int DEADLOCK_CYCLES = 24;
  localparam int REISSUE_CYCLES = 8;
  localparam int GLUE_WAIT_STATES = 1;
  localparam int TMR_W = 6;

  // Interagent message space sits in the top byte of the address map
  function automatic logic in_msg_space(input logic [31:0] a);
    in_msg_space = (a[31:MSG_TAG_LSB] == MSG_SPACE_TAG);
  endfunction

endpackage

/* File: design/bridge_link_if.sv */
// Local bus between the bridge and the module's glue logic.
// Assumes one clock; the shared address/data wire is resolved here.
`timescale 1ns/1ns
interface bridge_link_if;
  logic [31:0] br_lad_o;
  logic br_lad_oe;
  logic [31:0] gl_lad_o;
  logic gl_lad_oe;
  logic [31:0] local_addr_data;
  logic br_ads;
  logic br_wr;
  logic [3:0] br_be;
  logic [1:0] br_cnt;
  logic br_rdy;
  logic br_hold;
  logic gl_ads;
  logic gl_wr;
  logic [3:0] gl_be;
  logic gl_rdy;
  logic gl_hlda;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // Bridge wins if both drive; a quiet bus reads as zero
  assign local_addr_data = br_lad_oe ? br_lad_o : (gl_lad_oe ? gl_lad_o : 32'h0);

  modport bridge_end (
    output br_lad_o, br_lad_oe, br_ads, br_wr, br_be, br_cnt, br_rdy, br_hold,
    input local_addr_data, gl_ads, gl_wr, gl_be, gl_rdy, gl_hlda
  );
  modport glue_end (
    output gl_lad_o, gl_lad_oe, gl_ads, gl_wr, gl_be, gl_rdy, gl_hlda,
    input local_addr_data, br_ads, br_wr, br_be, br_cnt, br_rdy, br_hold
  );
endinterface

/* File: design/local_bus_if_control.sv */
// Module-side glue on the local bus: static-memory interface and a simple
// local master that issues requests to the bridge. Assumes one clock.
`timescale 1ns/1ns
module local_bus_if_control
  import bridge_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  bridge_link_if.glue_end lb,
  input wire logic [1:0] own_type,
  output logic burst_active_flag,
  output logic [31:0] sram_addr,
  output logic [3:0] sram_be_n,
  output logic sram_ce_n,
  output logic sram_oe_n,
  output logic sram_we_n,
  output logic [31:0] sram_wdata,
  input wire logic [31:0] sram_rdata,
  input wire logic host_valid,
  input wire logic host_wr,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_data,
  output logic host_ready,
  output logic host_done,
  output logic host_err,
  output logic [31:0] host_rdata
);
  import bridge_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {G_IDLE = 2'b00, G_WAIT = 2'b01, G_NEXT = 2'b10} gstate_t;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_ADDR = 2'b01, P_DATA = 2'b10} pstate_t;

  typedef struct packed {
    gstate_t gs;
    pstate_t ps;
    logic [31:0] addr;
    logic [3:0] be;
    logic [1:0] cnt;
    logic wr;
    logic sel;
    logic [1:0] wcnt;
    logic busy;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [31:0] wdata;
    logic [31:0] lad_o;
    logic lad_oe;
    logic rdy;
    logic ads;
    logic gwr;
    logic hlda;
    logic [31:0] hdata;
    logic host_ready;
    logic host_done;
    logic host_err;
    logic [31:0] host_rdata;
  } gluestate_t;

  gluestate_t r_reg;
  gluestate_t r_next;

  logic host_legal;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.rdy = 1'b0;
    r_next.ads = 1'b0;
    r_next.we_n = 1'b1;
    r_next.host_ready = 1'b0;
    r_next.host_done = 1'b0;
    r_next.host_err = 1'b0;

    // Passive sends nothing; mixed sends messages only
    host_legal = (own_type == MT_ACTIVE) ||
                 ((own_type == MT_MIXED) && in_msg_space(host_addr));

    // Memory slave: latch address, count burst words
    unique case (r_reg.gs)
      G_IDLE: begin
        if (lb.br_ads) begin
          r_next.addr = lb.local_addr_data;
          r_next.be = lb.br_be;
          r_next.cnt = lb.br_cnt;
          r_next.wr = lb.br_wr;
          // Message space is never decoded to memory
          r_next.sel = !in_msg_space(lb.local_addr_data);
          r_next.wcnt = 2'(GLUE_WAIT_STATES);
          r_next.busy = 1'b1;
          r_next.ce_n = in_msg_space(lb.local_addr_data);
          r_next.oe_n = lb.br_wr || in_msg_space(lb.local_addr_data);
          r_next.gs = G_WAIT;
        end
      end
      G_WAIT: begin
        if (r_reg.wcnt == 2'h0) begin
          r_next.rdy = 1'b1;
          if (r_reg.wr) begin
            r_next.we_n = !r_reg.sel;
            r_next.wdata = lb.local_addr_data;
          end else begin
            r_next.lad_o = r_reg.sel ? sram_rdata : 32'h0;
            r_next.lad_oe = 1'b1;
          end
          r_next.gs = G_NEXT;
        end else begin
          r_next.wcnt = r_reg.wcnt - 2'h1;
        end
      end
      G_NEXT: begin
        r_next.lad_oe = 1'b0;
        if (r_reg.cnt == 2'h0) begin
          r_next.busy = 1'b0;
          r_next.ce_n = 1'b1;
          r_next.oe_n = 1'b1;
          r_next.gs = G_IDLE;
        end else begin
          // Next word of the burst within the same 16-byte line
          r_next.cnt = r_reg.cnt - 2'h1;
          r_next.addr[WORD_LSB+1:WORD_LSB] = r_reg.addr[WORD_LSB+1:WORD_LSB] + 2'h1;
          r_next.wcnt = 2'(GLUE_WAIT_STATES);
          r_next.gs = G_WAIT;
        end
      end
      default: r_next.gs = G_IDLE;
    endcase

    // Local master toward the bridge; yields the bus on hold
    unique case (r_reg.ps)
      P_IDLE: begin
        r_next.hlda = lb.br_hold;
        if (!lb.br_hold && !r_reg.hlda && host_valid && !r_reg.host_ready) begin
          r_next.host_ready = 1'b1;
          if (!host_legal) begin
            r_next.host_err = 1'b1;
          end else begin
            r_next.ads = 1'b1;
            r_next.gwr = host_wr;
            r_next.lad_o = host_addr;
            r_next.lad_oe = 1'b1;
            r_next.hdata = host_data;
            r_next.ps = P_ADDR;
          end
        end
      end
      P_ADDR: begin
        r_next.lad_o = r_reg.hdata;
        r_next.lad_oe = r_reg.gwr;
        r_next.ps = P_DATA;
      end
      P_DATA: begin
        if (lb.br_rdy) begin
          r_next.host_done = 1'b1;
          r_next.host_rdata = r_reg.gwr ? 32'h0 : lb.local_addr_data;
          r_next.lad_oe = 1'b0;
          r_next.ps = P_IDLE;
        end
      end
      default: r_next.ps = P_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Strobes idle high after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.ce_n <= 1'b1;
      r_reg.oe_n <= 1'b1;
      r_reg.we_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lb.gl_lad_o = r_reg.lad_o;
  assign lb.gl_lad_oe = r_reg.lad_oe;
  assign lb.gl_ads = r_reg.ads;
  assign lb.gl_wr = r_reg.gwr;
  assign lb.gl_be = BE_ALL;
  assign lb.gl_rdy = r_reg.rdy;
  assign lb.gl_hlda = r_reg.hlda;
  assign burst_active_flag = r_reg.busy;
  assign sram_addr = r_reg.addr;
  assign sram_be_n = ~r_reg.be;
  assign sram_ce_n = r_reg.ce_n;
  assign sram_oe_n = r_reg.oe_n;
  assign sram_we_n = r_reg.we_n;
  assign sram_wdata = r_reg.wdata;
  assign host_ready = r_reg.host_ready;
  assign host_done = r_reg.host_done;
  assign host_err = r_reg.host_err;
  assign host_rdata = r_reg.host_rdata;

endmodule // local_bus_if_control

/* File: testbench/bridge_link_monitor.sv */
// Concurrent checks on the local bus between bridge and glue logic.
// Assumes the testbench hands in the interface signals and one clock.
`timescale 1ns/1ns
module bridge_link_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic br_lad_oe,
  input wire logic gl_lad_oe,
  input wire logic br_ads,
  input wire logic [1:0] br_cnt,
  input wire logic gl_ads,
  input wire logic gl_rdy,
  input wire logic br_rdy,
  input wire logic br_hold,
  input wire logic gl_hlda
);
  // ----------------------------------------
  // Local bus protocol
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_strobe_drives_lad: assert property (br_ads |-> br_lad_oe)
    else $error("bridge strobe without address drive");
  a_single_lad_driver: assert property (!(br_lad_oe && gl_lad_oe))
    else $error("both ends drive the shared wire");
  // Glue latches on the cycle after the strobe, then counts its wait state
  a_glue_wait_state: assert property (br_ads |-> !gl_rdy ##1 !gl_rdy ##1 !gl_rdy ##1 gl_rdy)
    else $error("glue ready not three cycles after strobe");
  a_strobe_pulse: assert property (br_ads |=> !br_ads)
    else $error("bridge strobe longer than one cycle");
  a_glue_strobe_pulse: assert property (gl_ads |=> !gl_ads)
    else $error("glue strobe longer than one cycle");
  a_word_spacing: assert property (gl_rdy |=> !gl_rdy [*2])
    else $error("burst words closer than three cycles");
  // A single-word burst must not leave stray ready pulses behind
  a_single_word_end: assert property (br_ads && br_cnt == 2'h0 |-> ##4 !gl_rdy [*3])
    else $error("extra ready after single word");
  a_slave_ready_late: assert property (gl_ads |=> !br_rdy ##1 !br_rdy)
    else $error("bridge slave ready too early");
  a_grant_after_hold: assert property ($rose(gl_hlda) |-> $past(br_hold))
    else $error("grant without a bus request");

  c_master_cycle: cover property (br_ads);
  c_slave_cycle: cover property (gl_ads);
  c_hold_grant: cover property (br_hold && gl_hlda);
endmodule // bridge_link_monitor

/* File: testbench/bridge_module_role_deadlock_tb_top.sv */
// Self-checking bench joining bridge and glue logic across the local bus.
// Assumes the package constants and one 250 MHz clock.
`timescale 1ns/1ns
module bridge_module_role_deadlock_tb_top;
  import bridge_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic proc_mode = 1'b0, in_valid = 1'b0, in_msg = 1'b0, in_cpu = 1'b0, in_wr = 1'b0;
  logic out_ready = 1'b0, orep_valid = 1'b0, host_valid = 1'b0, host_wr = 1'b0, seq_en = 1'b0, e = 1'b0;
  logic [1:0] own_type = MT_PASSIVE, gown = MT_PASSIVE, in_src = MT_ACTIVE, in_cnt = 2'h0;
  logic [1:0] orep_kind = RK_OK, msg_clr = 2'h0, k = 2'h0;
  logic [31:0] in_addr = 32'h0, in_data = 32'h0, host_addr = 32'h0, host_data = 32'h0;
  logic [31:0] sram_rdata = 32'h0, wa = 32'h0, wd = 32'h0;
  logic in_ready, rep_valid, rep_last, out_valid, deadlock, sram_we_n, host_ready, host_done, host_err;
  logic [1:0] rep_kind, msg_int;
  logic [31:0] rep_data, sram_addr, sram_wdata;
  int err_count = 0, cmp_count = 0, ads_n = 0, dl_n = 0, done_n = 0;

  bridge_link_if link();
  bus_bridge_unit bus_bridge_unit_inst (.sys_clk, .rst_n, .lb(link.bridge_end), .proc_mode, .own_type,
    .seq_en, .seq_base(32'hFF000000), .seq_mask(32'hFF000000), .in_valid, .in_msg, .in_cpu, .in_src, .in_wr,
    .in_addr, .in_data, .in_be(BE_ALL), .in_cnt, .in_ready, .rep_valid, .rep_kind, .rep_data, .rep_last,
    .out_valid, .out_ready, .out_wr(), .out_addr(), .out_data(), .out_be(), .out_seq(), .orep_valid,
    .orep_kind, .orep_data(32'h0), .msg_int, .msg_clr, .deadlock);
  local_bus_if_control local_bus_if_control_inst (.sys_clk, .rst_n, .lb(link.glue_end), .own_type(gown),
    .burst_active_flag(), .sram_addr, .sram_be_n(), .sram_ce_n(), .sram_oe_n(), .sram_we_n, .sram_wdata,
    .sram_rdata, .host_valid, .host_wr, .host_addr, .host_data, .host_ready, .host_done, .host_err,
    .host_rdata());
  bridge_link_monitor bridge_link_monitor_inst (.sys_clk, .rst_n, .br_lad_oe(link.br_lad_oe),
    .gl_lad_oe(link.gl_lad_oe), .br_ads(link.br_ads), .br_cnt(link.br_cnt), .gl_ads(link.gl_ads),
    .gl_rdy(link.gl_rdy), .br_rdy(link.br_rdy), .br_hold(link.br_hold), .gl_hlda(link.gl_hlda));

  always #2 sys_clk = ~sys_clk;

  // Capture memory writes and count strobes seen on the wire
  always @(posedge sys_clk) begin
    if (sram_we_n === 1'b0) begin
      wa <= sram_addr;
      wd <= sram_wdata;
    end
    if (link.br_ads === 1'b1) ads_n++;
    if (deadlock === 1'b1) dl_n++;
    if (host_done === 1'b1) done_n++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Inbound request; outputs sampled at the edge, so values are pre-update
  task automatic inb(input logic m, c, input logic [1:0] s, input logic w, input logic [31:0] a, d,
    input logic [1:0] cnt, input logic [31:0] rd);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    {in_valid, in_msg, in_cpu, in_src, in_wr, in_addr, in_data, in_cnt} <= {1'b1, m, c, s, w, a, d, cnt};
    for (int n = 0; n < 80 && !done; n++) begin
      @(posedge sys_clk);
      if (in_ready === 1'b1) in_valid <= 1'b0;
      if (rep_valid === 1'b1) begin
        k = rep_kind;
        if (k === RK_OK && !w) check(rep_data, rd, "read data");
        done = (rep_last === 1'b1) || (k !== RK_OK);
      end
    end
    in_valid <= 1'b0;
    if (!done) check(32'h0, 32'h1, "no inbound reply");
  endtask

  task automatic host(input logic w, input logic [31:0] a, d);
    logic g;
    g = 1'b0;
    e = 1'b0;
    @(posedge sys_clk);
    {host_valid, host_wr, host_addr, host_data} <= {1'b1, w, a, d};
    for (int n = 0; n < 40 && !g; n++) begin
      @(posedge sys_clk);
      g = (host_ready === 1'b1) || (host_err === 1'b1);
      e = e | (host_err === 1'b1);
    end
    host_valid <= 1'b0;
  endtask

  // Hang guard: the full run needs well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int i;
    logic [31:0] a, d, r;
    logic w, g;
    i = $urandom(32'hF60AA17B);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Memory mode: bridge masters every access, first a read then a write
    for (i = 0; i < 12; i++) begin
      a = $urandom() & 32'h7FFFFFFC;
      d = $urandom();
      r = $urandom();
      w = (i < 2) ? i[0] : 1'($urandom());
      sram_rdata <= r;
      inb(1'b0, 1'b0, MT_ACTIVE, w, a, d, w ? 2'h0 : 2'(i), r);
      check(32'(k), 32'(RK_OK), "memory reply kind");
      if (w) check(wa, a, "latched address");
      if (w) check(wd, d, "written data");
    end
    inb(1'b1, 1'b0, MT_ACTIVE, 1'b1, 32'hFF000000, 32'h1, 2'h0, 32'h0);
    check(32'(k), 32'(RK_NACK), "message in memory mode");
    $display("test memory_mode done");
    // Active module: no inbound memory, messages raise interrupts
    proc_mode <= 1'b1;
    own_type <= MT_ACTIVE;
    g = 1'b0;
    i = ads_n;
    inb(1'b0, 1'b0, MT_ACTIVE, 1'b0, 32'h100, 32'h0, 2'h0, 32'h0);
    check(32'(k), 32'(RK_NACK), "inbound memory refused");
    check(32'(ads_n), 32'(i), "no local strobe");
    for (int c = 0; c < 3; c++) begin
      inb(1'b1, c[0], MT_ACTIVE, 1'b1, 32'hFF000010, $urandom(), 2'h0, 32'h0);
      check(32'(k), (c < 2) ? 32'(RK_OK) : 32'(RK_NACK), "message reply");
    end
    repeat (2) @(posedge sys_clk);
    check(32'(msg_int), 32'h3, "message interrupts set");
    msg_clr <= 2'h3;
    @(posedge sys_clk);
    msg_clr <= 2'h0;
    repeat (2) @(posedge sys_clk);
    check(32'(msg_int), 32'h0, "message interrupts cleared");
    $display("test active_module done");
    // Mixed module: stalled outbound write forces a reissue reply
    own_type <= MT_MIXED;
    gown <= MT_MIXED;
    host(1'b1, 32'hFF000200, $urandom());
    check(32'(e), 32'h0, "mixed host write accepted");
    repeat (12) @(posedge sys_clk);
    inb(1'b0, 1'b0, MT_ACTIVE, 1'b0, 32'h300, 32'h0, 2'h0, 32'h0);
    check(32'(k), 32'(RK_REISSUE), "reissue while outbound stalls");
    out_ready <= 1'b1;
    for (i = 0; i < 30 && !g; i++) begin
      @(posedge sys_clk);
      g = (host_done === 1'b1);
    end
    check(32'(g), 32'h1, "outbound write completed");
    {out_ready, orep_valid, orep_kind} <= {1'b0, 1'b1, RK_OK};
    @(posedge sys_clk);
    orep_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Ordered range: the write is held in wait states until its reply
    seq_en <= 1'b1;
    i = done_n;
    host(1'b1, 32'hFF000204, $urandom());
    out_ready <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(32'(done_n), 32'(i), "ordered write held");
    {out_ready, orep_valid, orep_kind} <= {1'b0, 1'b1, RK_OK};
    @(posedge sys_clk);
    orep_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'(done_n), 32'(i + 1), "ordered write done on reply");
    // Active source into mixed memory: bridge asks for the bus first
    inb(1'b0, 1'b0, MT_ACTIVE, 1'b0, 32'h500, 32'h0, 2'h0, sram_rdata);
    check(32'(k), 32'(RK_OK), "mixed memory read after grant");
    inb(1'b0, 1'b0, MT_MIXED, 1'b0, 32'h300, 32'h0, 2'h0, 32'h0);
    check(32'(k), 32'(RK_NACK), "mixed to mixed memory refused");
    $display("test mixed_module done");
    // Passive glue sends nothing
    gown <= MT_PASSIVE;
    host(1'b1, 32'h400, 32'h5);
    check(32'(e), 32'h1, "passive host refused");
    check(32'(dl_n), 32'h0, "no deadlock in serviced traffic");
    $display("test passive_host done");
    // Deadlock watch: two short waits must not add up, a long one flags once
    proc_mode <= 1'b0;
    for (int t = 0; t < 3; t++) begin
      in_valid <= 1'b1;
      repeat ((t < 2) ? DEADLOCK_CYCLES - 4 : DEADLOCK_CYCLES + 2) @(posedge sys_clk);
      in_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(32'(dl_n), (t < 2) ? 32'h0 : 32'h1, "deadlock pulse count");
    end
    $display("test deadlock_watch done");
    report_and_stop();
  end
endmodule // bridge_module_role_deadlock_tb_top
